// >>> hw/card_port_regs.svh
/*
 * Constants for the card host-port strobe and flow logic.
 * Assumes inclusion by bare name from the package and card_read_strobe_and_udma_flow.
 */
`ifndef CARD_PORT_REGS_SVH
`define CARD_PORT_REGS_SVH

`define CARD_DATA_W 16
`define XFER_FIFO_DEPTH 8
`define SENSE_RESET_VAL 1'b0
`define DATA_RESET_VAL 16'h0000

`endif

// >>> hw/card_port_pkg.sv
/*
 * Types for the card host-port strobe and flow logic.
 * Assumes card_port_regs.svh on the include path.
 */
`include "card_port_regs.svh"

package card_port_pkg;

    // ------------------------------------------------------------
    // pin groups
    // ------------------------------------------------------------
    typedef struct packed {
        logic iord_n;
        logic hdmardy_n;
        logic hstrobe;
        logic dmack_n;
        logic [`CARD_DATA_W-1:0] data;
    } pins_in_t;

    typedef struct packed {
        logic [`CARD_DATA_W-1:0] data;
        logic data_oe;
        logic dmarq;
        logic card_present_sense_a;
        logic card_present_sense_b;
        logic tx_toggle;
    } pins_out_t;

    // ------------------------------------------------------------
    // transfer state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_IO_READ = 2'b01,
        ST_UDMA_IN = 2'b10,
        ST_UDMA_OUT = 2'b11
    } xfer_state_t;

    typedef struct packed {
        pins_in_t s1;
        pins_in_t s2;
        pins_in_t s3;
        xfer_state_t st;
        pins_out_t po;
        logic rd_strobe;
        logic src_ready;
        logic overflow;
    } port_state_t;

endpackage

// >>> hw/word_fifo.sv
/*
 * Word FIFO with valid/ready on both sides.
 * Assumes one clock domain; depth is a power of two.
 */
`timescale 1ns/1ps

module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW:0] wptr;
        logic [AW:0] rptr;
    } fifo_state_t;

    fifo_state_t r_q;
    fifo_state_t r_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (r_q.wptr - r_q.rptr) != (AW+1)'(DEPTH);
    assign out_valid = r_q.wptr != r_q.rptr;
    assign out_data = mem[r_q.rptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        r_d = r_q;
        if (push)
        begin
            r_d.wptr = r_q.wptr + 1'b1;
        end
        if (pop)
        begin
            r_d.rptr = r_q.rptr + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[r_q.wptr[AW-1:0]] <= in_data;
        end
    end

endmodule

// >>> hw/card_read_strobe_and_udma_flow.sv
/*
 * Card-side read strobe, Ultra DMA flow control and card-detect outputs.
 * Assumes all pin inputs are asynchronous to clk_sys; mode and user-side
 * signals come from logic on clk_sys. Host strobes are far slower than clk_sys.
 */
`timescale 1ns/1ps
`include "card_port_regs.svh"

// Overview of operation
// - In I/O mode read data is driven onto the bus only while the read strobe is asserted.
// - In True IDE mode without an Ultra DMA transfer the read strobe acts as in I/O mode.
// - When the host negates its ready line the card stops sending until it is asserted again.
// - During an Ultra DMA write a word is captured on every rising and falling host strobe edge while the FIFO has room.
// - A pause in host strobe edges loses or duplicates no data and capture resumes on new edges.
// - The request line stays asserted until the acknowledge comes and reasserts if read data remains or, in a write, the FIFO has room.
module card_read_strobe_and_udma_flow (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire card_port_pkg::pins_in_t pin_in,
    output card_port_pkg::pins_out_t pin_out,
    input wire logic io_mode,
    input wire logic true_ide_mode,
    input wire logic udma_read_active,
    input wire logic udma_write_active,
    input wire logic [`CARD_DATA_W-1:0] io_rd_data,
    output logic io_rd_strobe,
    input wire logic src_valid,
    input wire logic [`CARD_DATA_W-1:0] src_data,
    output logic src_ready,
    output logic snk_valid,
    output logic [`CARD_DATA_W-1:0] snk_data,
    input wire logic snk_ready,
    output logic overflow
);
    import card_port_pkg::*;

    port_state_t r_q;
    port_state_t r_d;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic strobe_edge;
    logic udma_any;
    logic want_req;

    // ------------------------------------------------------------
    // capture fifo for data-out bursts
    // ------------------------------------------------------------
    word_fifo #(
        .WIDTH(`CARD_DATA_W),
        .DEPTH(`XFER_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(fifo_in_valid),
        .in_data(r_q.s2.data),
        .in_ready(fifo_in_ready),
        .out_valid(snk_valid),
        .out_data(snk_data),
        .out_ready(snk_ready)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    assign udma_any = true_ide_mode && (udma_read_active || udma_write_active);
    // either edge, judged after synchronising
    assign strobe_edge = r_q.s2.hstrobe != r_q.s3.hstrobe;
    assign fifo_in_valid = (r_q.st == ST_UDMA_OUT) && strobe_edge;

    always_comb
    begin
        r_d = r_q;
        r_d.s1 = pin_in;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        r_d.rd_strobe = 1'b0;
        r_d.src_ready = 1'b0;
        want_req = 1'b0;
        if (true_ide_mode && udma_read_active)
        begin
            r_d.st = ST_UDMA_IN;
        end
        else if (true_ide_mode && udma_write_active)
        begin
            r_d.st = ST_UDMA_OUT;
        end
        else if (!r_q.s2.iord_n && (io_mode || true_ide_mode))
        begin
            r_d.st = ST_IO_READ;
        end
        else
        begin
            r_d.st = ST_IDLE;
        end
        case (r_d.st)
            ST_IO_READ:
            begin
                r_d.po.data_oe = 1'b1;
                r_d.po.data = io_rd_data;
                r_d.rd_strobe = (r_q.st != ST_IO_READ);
            end
            ST_UDMA_IN:
            begin
                r_d.po.data_oe = 1'b1;
                want_req = src_valid;
                // every other cycle, under acknowledge, only while host ready
                r_d.src_ready = (r_q.st == ST_UDMA_IN) && !r_q.s2.hdmardy_n
                    && !r_q.s2.dmack_n && !r_q.src_ready;
                if (r_q.src_ready && src_valid)
                begin
                    r_d.po.data = src_data;
                    r_d.po.tx_toggle = !r_q.po.tx_toggle;
                end
            end
            ST_UDMA_OUT:
            begin
                r_d.po.data_oe = 1'b0;
                want_req = fifo_in_ready;
            end
            default:
            begin
                r_d.po.data_oe = 1'b0;
            end
        endcase
        // request holds until acknowledge, then follows remaining work
        r_d.po.dmarq = want_req || (r_q.po.dmarq && r_q.s2.dmack_n && udma_any);
        if (fifo_in_valid && !fifo_in_ready)
        begin
            r_d.overflow = 1'b1;
        end
        r_d.po.card_present_sense_a = `SENSE_RESET_VAL;
        r_d.po.card_present_sense_b = `SENSE_RESET_VAL;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            r_q <= '0;
            r_q.s1 <= '{iord_n: 1'b1, hdmardy_n: 1'b1, hstrobe: 1'b0, dmack_n: 1'b1,
                data: `DATA_RESET_VAL};
            r_q.s2 <= '{iord_n: 1'b1, hdmardy_n: 1'b1, hstrobe: 1'b0, dmack_n: 1'b1,
                data: `DATA_RESET_VAL};
            r_q.s3 <= '{iord_n: 1'b1, hdmardy_n: 1'b1, hstrobe: 1'b0, dmack_n: 1'b1,
                data: `DATA_RESET_VAL};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign pin_out = r_q.po;
    assign io_rd_strobe = r_q.rd_strobe;
    assign src_ready = r_q.src_ready;
    assign overflow = r_q.overflow;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    property p_io_oe_with_strobe;
        (r_q.st == ST_IO_READ) |-> pin_out.data_oe && $past(r_q.s2.iord_n) == 1'b0;
    endproperty
    a_io_oe_with_strobe: assert property (p_io_oe_with_strobe)
        else $error("read data driven without read strobe");

    property p_oe_drops_after_strobe;
        (r_q.st == ST_IO_READ) && r_q.s2.iord_n && !udma_any |=> !pin_out.data_oe;
    endproperty
    a_oe_drops_after_strobe: assert property (p_oe_drops_after_strobe)
        else $error("read data still driven after strobe ended");

    property p_ide_read_strobe;
        true_ide_mode && !udma_read_active && !udma_write_active && (r_q.st == ST_IDLE)
            && !r_q.s2.iord_n |=> io_rd_strobe ##1 !io_rd_strobe;
    endproperty
    a_ide_read_strobe: assert property (p_ide_read_strobe)
        else $error("ide read strobe not handled as io read");

    property p_pause_in;
        r_q.s2.hdmardy_n |=> !src_ready;
    endproperty
    a_pause_in: assert property (p_pause_in)
        else $error("data taken while host not ready");

    property p_edge_capture;
        (r_q.st == ST_UDMA_OUT) && $changed(r_q.s2.hstrobe) |-> fifo_in_valid;
    endproperty
    a_edge_capture: assert property (p_edge_capture)
        else $error("strobe edge not captured");

    property p_no_dup;
        fifo_in_valid |=> !fifo_in_valid || $changed(r_q.s2.hstrobe);
    endproperty
    a_no_dup: assert property (p_no_dup)
        else $error("word captured twice for one edge");

    property p_req_hold;
        pin_out.dmarq && r_q.s2.dmack_n && udma_any |=> pin_out.dmarq;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before acknowledge");

    property p_ignore_idle;
        (r_q.st != ST_UDMA_OUT) |-> !fifo_in_valid ##1 ((r_q.st != ST_UDMA_IN) || !src_ready
            || $past(r_q.st) == ST_UDMA_IN);
    endproperty
    a_ignore_idle: assert property (p_ignore_idle)
        else $error("host flow signal used outside its burst");

    c_io_read: cover property (io_rd_strobe ##1 pin_out.data_oe);
    c_udma_in_word: cover property (src_ready && src_valid ##1 $changed(pin_out.tx_toggle));
    c_udma_out_word: cover property (fifo_in_valid ##[1:20] fifo_in_valid);
    c_pause: cover property ((r_q.st == ST_UDMA_IN) && r_q.s2.hdmardy_n [*3]);

endmodule

// >>> verification/host_model.sv
/*
 * Host-side model of the card bus: read strobe, ready, strobe, acknowledge.
 * Assumes the bench calls its tasks; pins change on falling clk_sys edges.
 */
`timescale 1ns/1ps

module host_model (
    input wire logic clk_sys,
    input wire card_port_pkg::pins_out_t pin_out,
    output card_port_pkg::pins_in_t pin_in,
    output logic present
);
    import card_port_pkg::*;

    // ------------------------------------------------------------
    // insertion and idle pins
    // ------------------------------------------------------------
    assign present = !pin_out.card_present_sense_a && !pin_out.card_present_sense_b;

    initial
    begin
        pin_in = '{iord_n: 1'b1, hdmardy_n: 1'b1, hstrobe: 1'b0, dmack_n: 1'b1, data: 16'hffff};
    end

    // ------------------------------------------------------------
    // host actions
    // ------------------------------------------------------------
    task automatic set_ready(input logic on);
        @(negedge clk_sys);
        pin_in.hdmardy_n = !on;
    endtask

    // no chip selects here; only 16-bit words move under acknowledge
    task automatic ack(input logic on);
        @(negedge clk_sys);
        pin_in.dmack_n = !on;
    endtask

    task automatic io_read(input int n);
        @(negedge clk_sys);
        pin_in.iord_n = 1'b0;
        repeat (n) @(negedge clk_sys);
        pin_in.iord_n = 1'b1;
    endtask

    // data settles 4 clocks before each edge and holds 4 after, or gap clocks ahead of word n/2
    task automatic strobe_words(input logic [15:0] first, input int n, input int gap);
        for (int i = 0; i < n; i++)
        begin
            repeat (i == n / 2 ? gap : 4) @(negedge clk_sys);
            pin_in.data = first + 16'(i);
            repeat (4) @(negedge clk_sys);
            pin_in.hstrobe = !pin_in.hstrobe;
        end
        repeat (4) @(negedge clk_sys);
        pin_in.data = ~pin_in.data;
    endtask
endmodule

// >>> verification/tb.sv
/*
 * Self-checking bench for the card read strobe and Ultra DMA flow block.
 * Assumes host_model on the pin side and the bench on the user side.
 */
`timescale 1ns/1ps

module tb;
    import card_port_pkg::*;

    logic clk_sys;
    logic resetn;
    pins_in_t pin_in;
    pins_out_t pin_out;
    logic io_mode;
    logic true_ide_mode;
    logic udma_read_active;
    logic udma_write_active;
    logic [15:0] io_rd_data;
    logic src_valid;
    logic [15:0] src_data;
    logic snk_ready;
    logic io_rd_strobe;
    logic src_ready;
    logic snk_valid;
    logic [15:0] snk_data;
    logic overflow;
    logic present;
    int err_count = 0;
    int check_count = 0;
    int seen;

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    card_read_strobe_and_udma_flow card_read_strobe_and_udma_flow_inst (
        .clk_sys(clk_sys), .resetn(resetn), .pin_in(pin_in), .pin_out(pin_out),
        .io_mode(io_mode), .true_ide_mode(true_ide_mode),
        .udma_read_active(udma_read_active), .udma_write_active(udma_write_active),
        .io_rd_data(io_rd_data), .io_rd_strobe(io_rd_strobe), .src_valid(src_valid),
        .src_data(src_data), .src_ready(src_ready), .snk_valid(snk_valid),
        .snk_data(snk_data), .snk_ready(snk_ready), .overflow(overflow)
    );

    host_model host_model_inst (
        .clk_sys(clk_sys), .pin_out(pin_out), .pin_in(pin_in), .present(present)
    );

    // ------------------------------------------------------------
    // compare and closing
    // ------------------------------------------------------------
    task automatic cmp_w(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_b(input logic got, input logic exp);
        cmp_w({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_read(input logic ide, input logic [15:0] w);
        io_mode = !ide;
        true_ide_mode = ide;
        io_rd_data = w;
        seen = 0;
        repeat (4) @(negedge clk_sys);
        cmp_b(pin_out.data_oe, 1'b0);
        fork
            host_model_inst.io_read(10);
            repeat (14) @(negedge clk_sys) seen += int'(io_rd_strobe);
            begin
                repeat (6) @(negedge clk_sys);
                cmp_b(pin_out.data_oe, 1'b1);
                cmp_w(pin_out.data, w);
            end
        join
        cmp_b(pin_out.data_oe, 1'b0);
        cmp_b(seen == 1, 1'b1);
    endtask

    task automatic take_words(input int n);
        logic t;
        src_valid = 1'b1;
        for (int i = 0; i < 60 && n > 0; i++)
        begin
            @(negedge clk_sys);
            if (src_ready === 1'b1)
            begin
                t = pin_out.tx_toggle;
                @(negedge clk_sys);
                cmp_w(pin_out.data, src_data);
                cmp_b(pin_out.tx_toggle, !t);
                src_data = src_data + 16'h0001;
                n--;
            end
        end
        src_valid = 1'b0;
        cmp_b(n == 0, 1'b1);
    endtask

    task automatic t_udma_in();
        true_ide_mode = 1'b1;
        io_mode = 1'b0;
        src_valid = 1'b1;
        seen = 0;
        host_model_inst.set_ready(1'b1);
        repeat (10) @(negedge clk_sys) seen += int'(src_ready);
        cmp_b(seen == 0, 1'b1);
        udma_read_active = 1'b1;
        repeat (8) @(negedge clk_sys);
        cmp_b(pin_out.dmarq, 1'b1);
        host_model_inst.ack(1'b1);
        take_words(4);
        host_model_inst.set_ready(1'b0);
        repeat (5) @(negedge clk_sys);
        repeat (12) @(negedge clk_sys) seen += int'(src_ready);
        cmp_b(seen == 0, 1'b1);
        host_model_inst.set_ready(1'b1);
        take_words(2);
        udma_read_active = 1'b0;
        host_model_inst.ack(1'b0);
        host_model_inst.set_ready(1'b0);
    endtask

    task automatic drain(input logic [15:0] first, input int n);
        for (int i = 0; i < n; i++)
        begin
            for (int k = 0; k < 10 && snk_valid !== 1'b1; k++) @(negedge clk_sys);
            cmp_w(snk_data, first + 16'(i));
            snk_ready = 1'b1;
            @(negedge clk_sys);
            snk_ready = 1'b0;
            @(negedge clk_sys);
        end
        repeat (3) @(negedge clk_sys);
        cmp_b(snk_valid, 1'b0);
    endtask

    task automatic t_udma_out();
        host_model_inst.strobe_words(16'h2000, 2, 4);
        cmp_b(snk_valid, 1'b0);
        udma_write_active = 1'b1;
        host_model_inst.strobe_words(16'h3000, 8, 30);
        cmp_b(overflow, 1'b0);
        drain(16'h3000, 8);
        host_model_inst.strobe_words(16'h4000, 9, 4);
        cmp_b(overflow, 1'b1);
        drain(16'h4000, 8);
        udma_write_active = 1'b0;
    endtask

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        resetn = 1'b0;
        io_mode = 1'b0;
        true_ide_mode = 1'b0;
        udma_read_active = 1'b0;
        udma_write_active = 1'b0;
        io_rd_data = 16'h0000;
        src_valid = 1'b0;
        src_data = 16'h0100;
        snk_ready = 1'b0;
        repeat (4) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
        cmp_b(pin_out.card_present_sense_a, 1'b0);
        cmp_b(present, 1'b1);
        t_read(1'b0, 16'h5a3c);
        t_read(1'b1, 16'ha5c3);
        t_udma_in();
        t_udma_out();
        finish_test();
    end

    initial
    begin
        #400000;
        err_count++;
        finish_test();
    end
endmodule
